// ---- hw/smbt_ctrl.v ----
// Behaviour
// [R01] drive async sram, nor flash, peripherals
// [R02] three independent timing register sets
// [R03] external data bus 8 or 16 bits
// [R04] 20 address/1 select or 24/4
// [R05] byte access on wide bus: large only
// [R06] ready select honours that set's ready
// [R07] page length 4, 8, 16, 32 words
// [R08] page reads only when page support set
// [R09] page read lasts page time plus one
// [R10] turnaround cycles when chip select changes; the code skips them between two writes
// [R11] write strobe lasts pulse time plus one
// [R12] hold address/data for write hold cycles
// [R13] address setup cycles before write strobe
// [R14] normal read lasts read time plus one
// [R15] devices appear memory mapped in kernel segment
// [R16] device holds ready low until done
// [R17] reset loads power-on timing defaults
`include "smbt_defines.vh"

module smbt_ctrl #(
    parameter LARGE_CFG = 1
) (
    input wire pclk, // clock, 20 MHz
    input wire presetn, // async reset, active low
    input wire ce, // clock enable, freezes state when low
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address or buffer write
    output reg [23:0] ext_addr, // external address
    output reg [15:0] ext_dout, // external data out
    output reg ext_doe_n, // data output enable, low drives
    input wire [15:0] ext_din, // external data in
    output reg [3:0] ext_cs_n, // chip selects, active low
    output reg ext_rd_n, // read strobe, active low
    output reg ext_wr_n, // write strobe, active low
    output reg [1:0] ext_be_n, // byte lane enables, active low
    input wire [2:0] ext_ready_input // ready pin of each set
);
    localparam AW = LARGE_CFG ? 24 : 20; // R04
    localparam NCS = LARGE_CFG ? 4 : 1; // R04
    localparam [23:0] AMASK = (24'h00_0001 << AW) - 24'h00_0001; // R04
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_TURN = 3'd2;
    localparam ST_SETUP = 3'd3;
    localparam ST_WPULSE = 3'd4;
    localparam ST_WHOLD = 3'd5;
    localparam ST_READ = 3'd6;

    // ==========================================================
    // apb slave
    wire setup_acc = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire wr_ok = done & pwrite & ~pslverr;
    wire buf_hit = paddr[`SMBT_BUF_BASE_BIT];
    wire reg_hit = ~buf_hit & (paddr[7:5] == 3'd0) & (paddr[1:0] == 2'd0);
    wire [15:0] buf_q;
    reg [31:0] rd_mux;

    reg [31:0] tset [0:2];
    reg [31:0] cfg;
    reg [23:0] addr_reg;
    reg [15:0] wdata_reg;
    reg [2:0] state;
    reg [5:0] cnt;
    reg [5:0] widx;
    reg [5:0] wtotal;
    reg [1:0] cur_set;
    reg [1:0] cur_cs;
    reg cur_wr;
    reg cur_byte;
    reg [1:0] last_cs;
    reg last_wr;
    reg have_last;
    reg [23:0] cur_addr;

    always @* begin
        case (paddr)
            `SMBT_OFF_TSET0: rd_mux = tset[0];
            `SMBT_OFF_TSET1: rd_mux = tset[1];
            `SMBT_OFF_TSET2: rd_mux = tset[2];
            `SMBT_OFF_CFG: rd_mux = cfg;
            `SMBT_OFF_ADDR: rd_mux = {8'h00, addr_reg};
            `SMBT_OFF_WDATA: rd_mux = {16'h0000, wdata_reg};
            `SMBT_OFF_STATUS: rd_mux = {18'h0_0000, widx, 6'h00, last_wr, state != ST_IDLE};
            default: rd_mux = buf_hit ? {16'h0000, buf_q} : 32'h0000_0000;
        endcase
    end

    // one wait state on every transfer so buffer reads come from a register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= setup_acc;
            pslverr <= setup_acc & ~(reg_hit | (buf_hit & ~pwrite));
            if (setup_acc & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // timing sets and control registers
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_tset
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tset[gi] <= `SMBT_TSET_RST; // R17
                end else if (ce & wr_ok & (paddr == (gi * 4))) begin
                    tset[gi] <= pwdata & `SMBT_TSET_MASK; // R02
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `SMBT_CFG_RST;
            addr_reg <= 24'h00_0000;
            wdata_reg <= 16'h0000;
        end else if (ce & wr_ok) begin
            if (paddr == `SMBT_OFF_CFG) begin
                cfg <= {31'h0000_0000, pwdata[`SMBT_CFG_BUS16_BIT]}; // R03
            end
            // offset inside the memory-mapped window of the kernel segment
            if (paddr == `SMBT_OFF_ADDR) begin
                addr_reg <= pwdata[23:0]; // R15
            end
            if (paddr == `SMBT_OFF_WDATA) begin
                wdata_reg <= pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // pin synchronisers and read buffer
    wire [15:0] din_s;
    wire [2:0] rdy_s;

    smbt_sync #(.WIDTH(16)) u_din_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(ext_din),
        .dout(din_s)
    );

    smbt_sync #(.WIDTH(3)) u_rdy_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(ext_ready_input),
        .dout(rdy_s)
    );

    // ==========================================================
    // active timing fields
    wire [31:0] ts = tset[cur_set];
    wire bus16 = cfg[`SMBT_CFG_BUS16_BIT];
    wire byte_ok = cur_byte & bus16 & (LARGE_CFG != 0); // R05
    wire rdy_ok = ~ts[`SMBT_RDY_BIT] | rdy_s[cur_set]; // R06 R16
    wire [5:0] read_cycle_time = ts[`SMBT_TRC_HI:`SMBT_TRC_LO];
    wire [1:0] addr_setup_time = ts[`SMBT_TAS_HI:`SMBT_TAS_LO];
    wire [1:0] write_hold_time = ts[`SMBT_TWR_HI:`SMBT_TWR_LO];
    wire [5:0] write_pulse_time = ts[`SMBT_TWP_HI:`SMBT_TWP_LO];
    wire [2:0] turnaround_time = ts[`SMBT_TURNAROUND_TIME_HI:`SMBT_TURNAROUND_TIME_LO];
    wire [3:0] page_read_time = ts[`SMBT_PAGE_READ_TIME_HI:`SMBT_PAGE_READ_TIME_LO];
    wire [1:0] psz = ts[`SMBT_PSZ_HI:`SMBT_PSZ_LO];
    wire [5:0] page_len = 6'd4 << psz; // R07
    // write to write on another select needs no turnaround
    wire turn_need = have_last & (last_cs != cur_cs) & ~(last_wr & cur_wr); // R10

    reg [15:0] rd_word;
    always @* begin
        if (!bus16) begin
            rd_word = {8'h00, din_s[7:0]};
        end else if (byte_ok) begin
            rd_word = {8'h00, cur_addr[0] ? din_s[15:8] : din_s[7:0]};
        end else begin
            rd_word = din_s;
        end
    end

    wire buf_we = ce & (state == ST_READ) & (cnt == 6'd0) & rdy_ok;

    smbt_rdbuf #(.DEPTH_LOG2(5), .WIDTH(16)) u_rdbuf (
        .pclk(pclk),
        .ce(ce),
        .wr_en(buf_we),
        .wr_idx(widx[4:0]),
        .wr_data(rd_word),
        .rd_idx(paddr[6:2]),
        .rd_data(buf_q)
    );

    wire [3:0] cs_onehot = 4'b0001 << cur_cs; // R04
    wire cmd_go = wr_ok & (paddr == `SMBT_OFF_CMD) & (state == ST_IDLE)
        & (pwdata[`SMBT_CMD_SET_HI:`SMBT_CMD_SET_LO] != 2'd3);

    // ==========================================================
    // bus cycle sequencer
    task launch;
        begin
            ext_addr <= cur_addr[23:0] & AMASK; // R04
            ext_cs_n <= ~cs_onehot;
            if (cur_wr) begin
                ext_doe_n <= 1'b0;
                ext_dout <= byte_ok ? {wdata_reg[7:0], wdata_reg[7:0]} : wdata_reg;
                ext_be_n <= !bus16 ? 2'b10 : byte_ok ? (cur_addr[0] ? 2'b01 : 2'b10) : 2'b00;
                if (addr_setup_time != 2'd0) begin
                    state <= ST_SETUP; // R13
                    cnt <= {4'h0, addr_setup_time - 2'd1};
                end else begin
                    state <= ST_WPULSE;
                    ext_wr_n <= 1'b0;
                    cnt <= write_pulse_time; // R11
                end
            end else begin
                ext_be_n <= !bus16 ? 2'b10 : byte_ok ? (cur_addr[0] ? 2'b01 : 2'b10) : 2'b00;
                ext_rd_n <= 1'b0; // R01
                state <= ST_READ;
                cnt <= read_cycle_time; // R14
            end
        end
    endtask

    task finish;
        begin
            state <= ST_IDLE;
            ext_cs_n <= 4'hF;
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            ext_doe_n <= 1'b1;
            ext_be_n <= 2'b11;
            last_cs <= cur_cs;
            last_wr <= cur_wr;
            have_last <= 1'b1;
        end
    endtask

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= 6'd0;
            widx <= 6'd0;
            wtotal <= 6'd1;
            cur_set <= 2'd0;
            cur_cs <= 2'd0;
            cur_wr <= 1'b0;
            cur_byte <= 1'b0;
            cur_addr <= 24'h00_0000;
            last_cs <= 2'd0;
            last_wr <= 1'b0;
            have_last <= 1'b0;
            ext_addr <= 24'h00_0000;
            ext_dout <= 16'h0000;
            ext_doe_n <= 1'b1;
            ext_cs_n <= 4'hF;
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            ext_be_n <= 2'b11;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (cmd_go) begin
                        cur_wr <= pwdata[`SMBT_CMD_WR_BIT];
                        cur_set <= pwdata[`SMBT_CMD_SET_HI:`SMBT_CMD_SET_LO];
                        cur_cs <= (NCS > 1) ? pwdata[`SMBT_CMD_CS_HI:`SMBT_CMD_CS_LO] : 2'd0;
                        cur_byte <= pwdata[`SMBT_CMD_BYTE_BIT];
                        cur_addr <= addr_reg;
                        widx <= 6'd0;
                        wtotal <= {5'd0, pwdata[`SMBT_CMD_PAGE_BIT]};
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    // bursts only on page-capable sets and only for reads
                    if (wtotal[0] & ts[`SMBT_PMODE_BIT] & ~cur_wr) begin
                        wtotal <= page_len; // R08
                    end else begin
                        wtotal <= 6'd1;
                    end
                    if (turn_need & (turnaround_time != 3'd0)) begin
                        state <= ST_TURN; // R10
                        cnt <= {3'd0, turnaround_time - 3'd1};
                    end else begin
                        launch;
                    end
                end
                ST_TURN: begin
                    if (cnt == 6'd0) begin
                        launch;
                    end else begin
                        cnt <= cnt - 6'd1;
                    end
                end
                ST_SETUP: begin
                    if (cnt == 6'd0) begin
                        state <= ST_WPULSE;
                        ext_wr_n <= 1'b0;
                        cnt <= write_pulse_time; // R11
                    end else begin
                        cnt <= cnt - 6'd1;
                    end
                end
                ST_WPULSE: begin
                    if (cnt != 6'd0) begin
                        cnt <= cnt - 6'd1;
                    end else if (rdy_ok) begin // R06
                        ext_wr_n <= 1'b1;
                        if (write_hold_time != 2'd0) begin
                            state <= ST_WHOLD; // R12
                            cnt <= {4'h0, write_hold_time - 2'd1};
                        end else begin
                            finish;
                        end
                    end
                end
                ST_WHOLD: begin
                    if (cnt == 6'd0) begin
                        finish; // R12
                    end else begin
                        cnt <= cnt - 6'd1;
                    end
                end
                ST_READ: begin
                    if (cnt != 6'd0) begin
                        cnt <= cnt - 6'd1;
                    end else if (rdy_ok) begin // R06
                        widx <= widx + 6'd1;
                        if (widx + 6'd1 == wtotal) begin
                            finish;
                        end else begin
                            cur_addr <= cur_addr + 24'h00_0001;
                            ext_addr <= (cur_addr + 24'h00_0001) & AMASK;
                            cnt <= {2'd0, page_read_time}; // R09
                        end
                    end
                end
                default: begin
                    finish;
                end
            endcase
        end
    end
endmodule // smbt_ctrl

// ---- hw/smbt_defines.vh ----
`ifndef SMBT_DEFINES_VH
`define SMBT_DEFINES_VH

// ==========================================================
// register byte offsets
`define SMBT_OFF_TSET0 8'h00
`define SMBT_OFF_TSET1 8'h04
`define SMBT_OFF_TSET2 8'h08
`define SMBT_OFF_CFG 8'h0C
`define SMBT_OFF_ADDR 8'h10
`define SMBT_OFF_WDATA 8'h14
`define SMBT_OFF_CMD 8'h18
`define SMBT_OFF_STATUS 8'h1C
`define SMBT_BUF_BASE_BIT 7

// ==========================================================
// timing set fields
`define SMBT_TSET_RST 32'h041C_2D4B
`define SMBT_TSET_MASK 32'h07FF_FFFF
`define SMBT_RDY_BIT 26
`define SMBT_PSZ_HI 25
`define SMBT_PSZ_LO 24
`define SMBT_PMODE_BIT 23
`define SMBT_PAGE_READ_TIME_HI 22
`define SMBT_PAGE_READ_TIME_LO 19
`define SMBT_TURNAROUND_TIME_HI 18
`define SMBT_TURNAROUND_TIME_LO 16
`define SMBT_TWP_HI 15
`define SMBT_TWP_LO 10
`define SMBT_TWR_HI 9
`define SMBT_TWR_LO 8
`define SMBT_TAS_HI 7
`define SMBT_TAS_LO 6
`define SMBT_TRC_HI 5
`define SMBT_TRC_LO 0

// ==========================================================
// control, command and status fields
`define SMBT_CFG_RST 32'h0000_0001
`define SMBT_CFG_BUS16_BIT 0
`define SMBT_CMD_WR_BIT 0
`define SMBT_CMD_SET_HI 2
`define SMBT_CMD_SET_LO 1
`define SMBT_CMD_CS_HI 4
`define SMBT_CMD_CS_LO 3
`define SMBT_CMD_PAGE_BIT 5
`define SMBT_CMD_BYTE_BIT 6
`define SMBT_ST_BUSY_BIT 0
`define SMBT_ST_LASTWR_BIT 1
`define SMBT_ST_CNT_HI 13
`define SMBT_ST_CNT_LO 8

`endif

// ---- hw/smbt_sync.v ----
// ==========================================================
// two-stage synchroniser for pin inputs
module smbt_sync #(
    parameter WIDTH = 1
) (
    input wire pclk, // clock
    input wire presetn, // async reset, active low
    input wire ce, // clock enable
    input wire [WIDTH-1:0] din, // asynchronous pin level
    output reg [WIDTH-1:0] dout // synchronised level
);
    reg [WIDTH-1:0] meta;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // smbt_sync

// ---- hw/smbt_rdbuf.v ----
// ==========================================================
// page read buffer, registered read port
module smbt_rdbuf #(
    parameter DEPTH_LOG2 = 5,
    parameter WIDTH = 16
) (
    input wire pclk, // clock
    input wire ce, // clock enable
    input wire wr_en, // write strobe
    input wire [DEPTH_LOG2-1:0] wr_idx, // write index
    input wire [WIDTH-1:0] wr_data, // write data
    input wire [DEPTH_LOG2-1:0] rd_idx, // read index
    output reg [WIDTH-1:0] rd_data // read data, one cycle after index
);
    reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

    always @(posedge pclk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= mem[rd_idx];
        end
    end
endmodule // smbt_rdbuf

// ---- tb/smbt_props.sv ----
// ==========================================================
// port checks for the bus timing controller
module smbt_props (
    input wire pclk, // clock
    input wire presetn, // reset, low
    input wire ce, // clock enable
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb address
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire ext_doe_n, // data drive, low
    input wire [3:0] ext_cs_n, // selects, low
    input wire ext_rd_n, // read strobe, low
    input wire ext_wr_n, // write strobe, low
    input wire [1:0] ext_be_n // lanes, low
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        ##1 (psel && penable) ##1 pready;
    endsequence
    a_apb_answer: assert property (s_setup |-> s_access)
        else $error("apb answer not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready && !paddr[7] && paddr[6:5] != 2'b00 |-> pslverr)
        else $error("unmapped access without error");
    a_err_paired: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data changed outside a read");
    a_strobe_excl: assert property (!ext_rd_n |-> ext_wr_n && ext_doe_n)
        else $error("read strobe overlaps write or drive");
    a_write_drive: assert property (!ext_wr_n |-> !ext_doe_n && ext_be_n != 2'b11)
        else $error("write strobe without data driven");
    a_strobe_select: assert property (!(ext_rd_n && ext_wr_n) |-> ext_cs_n != 4'hF)
        else $error("strobe without chip select");
    a_cs_single: assert property ($onehot0(~ext_cs_n))
        else $error("more than one chip select");
endmodule // smbt_props

bind smbt_ctrl smbt_props i_smbt_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .ext_doe_n, .ext_cs_n, .ext_rd_n, .ext_wr_n, .ext_be_n);

// ---- tb/smbt_mem_model.sv ----
// ==========================================================
// static memory on the far side of the bus
module smbt_mem_model (
    input wire pclk, // clock
    input wire [23:0] ext_addr, // address
    input wire [15:0] ext_dout, // write data
    input wire [3:0] ext_cs_n, // selects, low
    input wire ext_rd_n, // read strobe, low
    input wire ext_wr_n, // write strobe, low
    input wire [1:0] ext_be_n, // lanes, low
    input wire [3:0] rdy_dly, // cycles before ready
    output logic [15:0] ext_din, // read data
    output logic [2:0] ext_ready_input // ready per set
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    logic [15:0] last = 16'h5A3C;
    logic [3:0] cnt = 4'h0;
    wire sel = ext_cs_n != 4'hF;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 16'h0137 + 16'h2B00);
    // undriven bus shows a pattern that flips every cycle
    assign ext_din = sel && !ext_rd_n ? mem[ext_addr[7:0]] : ~last;
    assign ext_ready_input = {3{cnt >= rdy_dly}};
    always @(posedge pclk) begin
        last <= ext_din;
        cnt <= !sel ? 4'h0 : cnt == 4'hF ? cnt : cnt + 4'h1;
        if (sel && !ext_wr_n && !ext_be_n[0]) mem[ext_addr[7:0]][7:0] <= ext_dout[7:0];
        if (sel && !ext_wr_n && !ext_be_n[1]) mem[ext_addr[7:0]][15:8] <= ext_dout[15:8];
    end
endmodule // smbt_mem_model

// ---- tb/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, a, d, seed;
    logic [31:0] ts [3];
    logic pready, pslverr, ext_doe_n, ext_rd_n, ext_wr_n;
    logic [23:0] ext_addr;
    logic [15:0] ext_dout, ext_din;
    logic [3:0] ext_cs_n, cs_seen, rdy_dly = 4'h0;
    logic [1:0] ext_be_n, be_seen;
    logic [2:0] ext_ready_input;
    int mismatches = 0, tests_run = 0, cyc = 0, t0, cs_t, wr_len, rd_len, setup, hold;
    int write_pulse_time, write_hold_time, addr_setup_time, read_cycle_time, turnaround_time, page_read_time, lat, n;

    always #25 pclk = ~pclk;
    smbt_ctrl #(.LARGE_CFG(1)) i_smbt_ctrl (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_addr, .ext_dout, .ext_doe_n,
        .ext_din, .ext_cs_n, .ext_rd_n, .ext_wr_n, .ext_be_n, .ext_ready_input);
    smbt_mem_model i_smbt_mem_model (.pclk, .ext_addr, .ext_dout, .ext_cs_n, .ext_rd_n,
        .ext_wr_n, .ext_be_n, .rdy_dly, .ext_din, .ext_ready_input);

    // ==========================================================
    // pin monitor and timeout
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ext_cs_n != 4'hF) begin
            if (cs_t == 0) cs_t <= cyc;
            cs_seen <= ext_cs_n;
            if (!ext_wr_n) begin
                wr_len <= wr_len + 1;
                be_seen <= ext_be_n;
            end else if (wr_len == 0) setup <= setup + 1;
            else hold <= hold + 1;
            if (!ext_rd_n) rd_len <= rd_len + 1;
        end
        if (cyc == 60000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    // ==========================================================
    // helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
            mismatches++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        chk("apb answer", 2, k);
    endtask

    task automatic ext_op(input logic [31:0] c);
        int k;
        wr_len = 0;
        rd_len = 0;
        setup = 0;
        hold = 0;
        cs_t = 0;
        apb(1, 8'h18, c);
        t0 = cyc;
        k = 0;
        do begin
            apb(0, 8'h1C, 0);
            k++;
        end while (q[0] !== 1'b0 && k < 300);
        if (k >= 300) begin
            chk("busy", 0, 1);
            close_out();
        end
    endtask

    function automatic logic [31:0] mk(input int rdy, pm, psz, pr, ta, wp, wh, su, rc);
        return {5'h00, rdy[0], psz[1:0], pm[0], pr[3:0], ta[2:0], wp[5:0], wh[1:0],
            su[1:0], rc[5:0]};
    endfunction

    function automatic logic [31:0] cmd(input int wr, set, cs, pg, byt);
        return {25'h000_0000, byt[0], pg[0], cs[1:0], set[1:0], wr[0]};
    endfunction

    function automatic int burst(input int words, pr, rc);
        return rc + 1 + (words - 1) * (pr + 1);
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        seed = $urandom(64);
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 3; k++) begin
            apb(0, 8'(4 * k), 0);
            chk("set reset", 32'h041C_2D4B, q);
        end
        apb(0, 8'h0C, 0);
        chk("cfg reset", 32'h0000_0001, q);
        apb(0, 8'h40, 0);
        chk("unmapped error", 1, e);
        for (int k = 0; k < 3; k++) begin
            ts[k] = $urandom & 32'h07FF_FFFF;
            apb(1, 8'(4 * k), ts[k] | 32'hF800_0000);
        end
        for (int k = 0; k < 3; k++) begin
            apb(0, 8'(4 * k), 0);
            chk("set readback", ts[k], q);
        end
        for (int r = 0; r < 4; r++) begin
            write_pulse_time = $urandom % 12;
            write_hold_time = $urandom % 4;
            addr_setup_time = 1 + $urandom % 3;
            read_cycle_time = 2 + $urandom % 10;
            a = $urandom;
            d = $urandom;
            rdy_dly <= 4'hF;
            apb(1, 8'h00, mk(0, 0, 0, 0, 0, write_pulse_time, write_hold_time, addr_setup_time, read_cycle_time));
            apb(1, 8'h04, mk(1, 0, 0, 0, 0, 0, 0, 1, read_cycle_time));
            apb(1, 8'h10, a);
            apb(1, 8'h14, d);
            ext_op(cmd(1, 0, 0, 0, 0));
            chk("write pulse", write_pulse_time + 1, wr_len);
            chk("address setup", addr_setup_time, setup);
            chk("write hold", write_hold_time, hold);
            chk("word lanes", 2'b00, be_seen);
            chk("last op write", 1, q[1]);
            ext_op(cmd(0, 0, 0, 0, 0));
            chk("read cycle", burst(1, 0, read_cycle_time), rd_len);
            chk("last op read", 0, q[1]);
            apb(0, 8'h80, 0);
            chk("read data", d[15:0], q);
            rdy_dly <= 4'(read_cycle_time + 4);
            ext_op(cmd(0, 1, 0, 0, 0));
            chk("ready wait", 1, rd_len > read_cycle_time + 1);
            apb(0, 8'h80, 0);
            chk("slow data", d[15:0], q);
        end
        turnaround_time = 1 + $urandom % 7;
        apb(1, 8'h04, mk(0, 0, 0, 0, turnaround_time, 0, 0, 1, 3));
        rdy_dly <= 4'h0;
        ext_op(cmd(0, 1, 0, 0, 0));
        ext_op(cmd(0, 1, 0, 0, 0));
        lat = cs_t - t0;
        ext_op(cmd(0, 1, 2, 0, 0));
        chk("turnaround", turnaround_time, cs_t - t0 - lat);
        chk("select line", 4'b1011, cs_seen);
        for (int p = 0; p < 4; p++) begin
            page_read_time = 2 + $urandom % 14;
            apb(1, 8'h08, mk(0, 1, p, page_read_time, 0, 0, 0, 1, 3));
            ext_op(cmd(0, 2, 0, 1, 0));
            n = 4 << p;
            chk("page words", n, q[13:8]);
            chk("page time", burst(n, page_read_time, 3), rd_len);
            for (int i = 0; i < n; i++) begin
                apb(0, 8'(8'h80 + 4 * i), 0);
                chk("page data", i_smbt_mem_model.mem[8'(a[7:0] + i)], q);
            end
        end
        apb(1, 8'h08, mk(0, 0, 3, 2, 0, 0, 0, 1, 3));
        ext_op(cmd(0, 2, 0, 1, 0));
        chk("no page words", 1, q[13:8]);
        chk("no page time", burst(1, 0, 3), rd_len);
        for (int k = 0; k < 3; k++) begin
            apb(1, 8'h0C, k != 2);
            apb(1, 8'h10, {a[31:1], k[0]});
            ext_op(cmd(1, 0, 0, 0, k < 2));
            chk("byte lanes", k == 1 ? 2'b01 : 2'b10, be_seen);
            ext_op(cmd(0, 0, 0, 0, k < 2));
            apb(0, 8'h80, 0);
            chk("byte read", d[7:0], q);
        end
        close_out();
    end
endmodule // tb
